// [dv/flash_card_pin_if_chk.sv]
// Assertion checker of the flash card pins.
`timescale 1ns/10ps
module flash_card_pin_if_chk
(
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire [10:0] addr_i,
   input wire card_enable_low_n_i,
   input wire card_enable_high_n_i,
   input wire disk_mode_select_n_i,
   input wire io_read_strobe_n_i,
   input wire io_write_strobe_n_i,
   input wire drive_role_select_n_i,
   input wire audio_supported_i,
   input wire audio_i,
   input wire udma_write_active_i,
   input wire udma_read_active_i,
   input wire device_burst_ready_n_i,
   input wire device_data_strobe_i,
   input wire data_lo_oe_n_o,
   input wire data_hi_oe_n_o,
   input wire pin45_o,
   input wire pin46_o,
   input wire pin42_o,
   input wire core_rd_req_o,
   input wire disk_compatible_mode_o,
   input wire io_card_mode_o,
   input wire drive_secondary_o
);
   // ----------
   // Sequences, all on the one system clock.
   // ----------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_mem; (!disk_compatible_mode_o && !io_card_mode_o)[*3]; endsequence
   sequence s_aud_on; (io_card_mode_o && audio_supported_i && audio_i)[*3]; endsequence
   sequence s_aud_off; (io_card_mode_o && !audio_supported_i)[*3]; endsequence
   sequence s_second; (disk_compatible_mode_o && drive_role_select_n_i)[*4]; endsequence
   sequence s_uw; (disk_compatible_mode_o && udma_write_active_i && $stable(device_burst_ready_n_i))[*3]; endsequence
   sequence s_ur; (disk_compatible_mode_o && udma_read_active_i && $stable(device_data_strobe_i))[*3]; endsequence
   sequence s_rd_idle; (io_card_mode_o && io_read_strobe_n_i && disk_mode_select_n_i)[*5]; endsequence
   sequence s_bad_ctrl;
      (disk_compatible_mode_o && card_enable_low_n_i && !card_enable_high_n_i && addr_i[2:0] != 3'h6)[*5];
   endsequence
   // ----------
   // Assertions.
   // ----------
   chk_batt_high: assert property (s_mem |-> pin45_o && pin46_o) else $error("battery outputs low");
   chk_audio_on: assert property (s_aud_on |-> !pin45_o) else $error("audio not shown");
   chk_audio_off: assert property (s_aud_off |-> pin45_o) else $error("audio not negated");
   chk_role_second: assert property (s_second |-> drive_secondary_o) else $error("not secondary");
   chk_role_ignored: assert property ((!disk_compatible_mode_o)[*2] |-> !drive_secondary_o)
      else $error("role used in card mode");
   chk_mode_kept: assert property (disk_compatible_mode_o |=> disk_compatible_mode_o && !io_card_mode_o)
      else $error("disk mode lost");
   chk_uw_pin42: assert property (s_uw |-> pin42_o == device_burst_ready_n_i) else $error("pin42 write burst");
   chk_ur_pin42: assert property (s_ur |-> pin42_o == device_data_strobe_i) else $error("pin42 read burst");
   chk_rd_idle: assert property (s_rd_idle |-> data_lo_oe_n_o && data_hi_oe_n_o) else $error("data driven idle");
   chk_bad_ctrl: assert property (s_bad_ctrl |-> !core_rd_req_o) else $error("bad control index read");
endmodule

bind flash_card_pin_if flash_card_pin_if_chk u_chk (.*);

// [dv/flash_host_model.sv]
// Host side model that drives the card pins for card and disk cycles.
`timescale 1ns/10ps
module flash_host_model
(
   input wire sys_clk_i,
   output reg [10:0] addr_o,
   output reg ce_lo_n_o,
   output reg ce_hi_n_o,
   output reg rd_n_o,
   output reg wr_n_o,
   output reg [15:0] data_o
);
   // ----------
   // Pin drivers, changed only just after a rising edge.
   // ----------
   // Idle pins at time zero.
   initial
   begin
      addr_o = 11'h000;
      ce_lo_n_o = 1'b1;
      ce_hi_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      data_o = 16'h5A3C;
   end
   // Presents address, enables and data until idle.
   task setup(input [10:0] a, input [1:0] ce_n, input [15:0] d);
   begin
      @(posedge sys_clk_i);
      addr_o <= a;
      ce_lo_n_o <= ce_n[0];
      ce_hi_n_o <= ce_n[1];
      data_o <= d;
   end
   endtask
   // Write pulse; taken at the trailing edge.
   task wr;
   begin
      pins(1'b1, 1'b0);
      pins(1'b1, 1'b1);
   end
   endtask
   // Moves the read strobe, waits for the answer.
   task rd(input on);
   begin
      pins(!on, 1'b1);
   end
   endtask
   // Sets both strobes, then waits out the synchronisers.
   task pins(input r, input w);
   begin
      @(posedge sys_clk_i);
      rd_n_o <= r;
      wr_n_o <= w;
      repeat (5) @(posedge sys_clk_i);
      #1;
   end
   endtask
   // Deselects; released data lines show the inverse.
   task idle;
   begin
      @(posedge sys_clk_i);
      ce_lo_n_o <= 1'b1;
      ce_hi_n_o <= 1'b1;
      data_o <= ~data_o;
   end
   endtask
endmodule

// [dv/tb_flash_card_pin_if.sv]
// Self-checking bench of the flash card host pin interface.
`timescale 1ns/10ps
module tb_flash_card_pin_if;
   // ----------
   // Stimulus and observed signals, named as the design ports.
   // ----------
   reg sys_clk_i = 1'b0, rst_b_i = 1'b0, disk_mode_select_n_i = 1'b1, drive_role_select_n_i = 1'b1;
   reg dma_acknowledge_n_i = 1'b1, io_mode_cfg_i = 1'b0, ready_state_i = 1'b0, write_protect_i = 1'b0;
   reg status_change_enable_i = 1'b0, status_change_clear_i = 1'b0, audio_supported_i = 1'b0, audio_i = 1'b0;
   reg udma_write_active_i = 1'b0, udma_read_active_i = 1'b0, device_burst_ready_n_i = 1'b1;
   reg device_data_strobe_i = 1'b0, core_wr_ready_i = 1'b0;
   reg [15:0] core_rd_data_i = 16'h0000;
   reg core_ready_i = 1'b1, diag_passed_i = 1'b0, drive_active_i = 1'b0, dma_active_i = 1'b0;
   wire write_enable_n_i = 1'b1;
   wire [10:0] addr_i, core_rd_addr_o;
   wire [15:0] data_i, data_o;
   wire [30:0] core_wr_entry_o;
   wire card_enable_low_n_i, card_enable_high_n_i, io_read_strobe_n_i, io_write_strobe_n_i, data_lo_oe_n_o;
   wire data_hi_oe_n_o, pin45_o, pin45_oe_n_o, pin46_o, pin46_oe_n_o, pin42_o, core_wr_valid_o, core_rd_req_o;
   wire core_rd_ctrl_o, disk_compatible_mode_o, io_card_mode_o, drive_secondary_o, host_data_strobe_o;
   wire host_burst_ready_n_o, stop_request_o;
   integer errors = 0, n_tests = 0, i, k, c;
   reg [31:0] r;
   reg [17:0] e;
   reg [15:0] m;
   initial
   begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   flash_host_model u_host (.sys_clk_i(sys_clk_i), .addr_o(addr_i), .ce_lo_n_o(card_enable_low_n_i),
      .ce_hi_n_o(card_enable_high_n_i), .rd_n_o(io_read_strobe_n_i), .wr_n_o(io_write_strobe_n_i), .data_o(data_i));
   flash_card_pin_if DUT (.*);
   // ----------
   // Checking, reset and expectation helpers.
   // ----------
   task chk(input ok, input string msg);
   begin
      n_tests = n_tests + 1;
      if (!ok)
      begin
         errors = errors + 1;
         $display("[ERR] %0t %s", $time, msg);
      end
   end
   endtask
   task print_verdict;
   begin
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   // Resets with mode pin and configuration held.
   task reset_dut(input dm, input cfg);
   begin
      @(posedge sys_clk_i);
      rst_b_i <= 1'b0;
      disk_mode_select_n_i <= dm;
      io_mode_cfg_i <= cfg;
      repeat (6) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      #1;
   end
   endtask
   // Buffered word as {enables, lanes}.
   function [17:0] exp_w(input [1:0] ce, input a0, input [15:0] d);
   begin
      case (ce)
         2'h0: exp_w = {2'h3, d};
         2'h2: exp_w = a0 ? {2'h2, d[7:0], 8'h00} : {2'h1, 8'h00, d[7:0]};
         default: exp_w = {2'h2, d[15:8], 8'h00};
      endcase
   end
   endfunction
   // Read answer as {oe_n pair, pins}.
   function [17:0] exp_r(input [1:0] ce, input a0, input [15:0] d);
   begin
      case (ce)
         2'h0: exp_r = {2'h0, d};
         2'h2: exp_r = {2'h2, 8'h00, a0 ? d[15:8] : d[7:0]};
         default: exp_r = {2'h1, d[15:8], 8'h00};
      endcase
   end
   endfunction
   // Waits for a buffered write, compares enabled lanes, takes it.
   task take(input [10:0] a, input [17:0] x);
   begin
      k = 0;
      while (core_wr_valid_o !== 1'b1 && k < 20)
      begin
         @(posedge sys_clk_i);
         k = k + 1;
      end
      #1;
      m = {{8{x[17]}}, {8{x[16]}}};
      chk(core_wr_entry_o[17:16] === x[17:16] && (core_wr_entry_o[15:0] & m) === (x[15:0] & m)
         && core_wr_entry_o[28:18] === a, "write entry");
      @(posedge sys_clk_i);
      core_wr_ready_i <= 1'b1;
      @(posedge sys_clk_i);
      core_wr_ready_i <= 1'b0;
   end
   endtask
   task hw(input [10:0] a, input [1:0] ce, input [15:0] d);
   begin
      u_host.setup(a, ce, d);
      u_host.wr;
      u_host.idle;
   end
   endtask
   // ----------
   // Watchdog and main sequence.
   // ----------
   initial
   begin
      #500000;
      errors = errors + 1;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict;
   end
   initial
   begin
      r = $urandom(78);
      reset_dut(1'b1, 1'b0);
      chk(pin45_o === 1'b1 && pin46_o === 1'b1 && io_card_mode_o === 1'b0, "battery level");
      chk(drive_secondary_o === 1'b0, "role pin used");
      reset_dut(1'b1, 1'b1);
      // Byte steering: corner cases, then random.
      for (i = 0; i < 14; i = i + 1)
      begin
         r = $urandom;
         c = (i < 6) ? i % 3 : $urandom % 3;
         if (i < 6)
            r[0] = i[1];
         hw(r[10:0], c[1:0], r[31:16]);
         take(r[10:0], exp_w(c[1:0], r[0], r[31:16]));
      end
      // Core stalls: third word lost, ready drops.
      for (i = 0; i < 3; i = i + 1)
         hw(11'h010 + i[10:0], 2'h0, {i[3:0], 12'h0A5});
      chk(pin42_o === 1'b0, "ready while full");
      take(11'h010, {2'h3, 16'h00A5});
      take(11'h011, {2'h3, 16'h10A5});
      repeat (6) @(posedge sys_clk_i);
      chk(core_wr_valid_o === 1'b0 && pin42_o === 1'b1, "lost word or ready");
      @(posedge sys_clk_i);
      status_change_enable_i <= 1'b1;
      ready_state_i <= 1'b1;
      audio_supported_i <= 1'b1;
      audio_i <= 1'b1;
      repeat (5) @(posedge sys_clk_i);
      #1;
      chk(pin46_o === 1'b0 && pin45_o === 1'b0, "change or audio");
      @(posedge sys_clk_i);
      status_change_clear_i <= 1'b1;
      audio_supported_i <= 1'b0;
      @(posedge sys_clk_i);
      status_change_clear_i <= 1'b0;
      status_change_enable_i <= 1'b0;
      write_protect_i <= 1'b1;
      repeat (5) @(posedge sys_clk_i);
      #1;
      chk(pin46_o === 1'b1 && pin45_o === 1'b1, "flag clear or gated");
      // Reads of each enable case.
      r = $urandom;
      core_rd_data_i <= r[15:0];
      for (i = 0; i < 4; i = i + 1)
      begin
         c = (i == 0) ? 0 : (i == 3) ? 1 : 2;
         u_host.setup({r[26:17], i[0]}, c[1:0], 16'h0000);
         u_host.rd(1'b1);
         e = exp_r(c[1:0], i[0], r[15:0]);
         m = {{8{!e[17]}}, {8{!e[16]}}};
         chk({data_hi_oe_n_o, data_lo_oe_n_o} === e[17:16] && (data_o & m) === (e[15:0] & m), "read lanes");
         u_host.rd(1'b0);
         u_host.idle;
      end
      reset_dut(1'b0, 1'b0);
      chk(disk_compatible_mode_o === 1'b1 && drive_secondary_o === 1'b1, "secondary drive");
      @(posedge sys_clk_i);
      disk_mode_select_n_i <= 1'b1;
      drive_role_select_n_i <= 1'b0;
      dma_acknowledge_n_i <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      #1;
      chk(disk_compatible_mode_o === 1'b1 && drive_secondary_o === 1'b0, "mode or primary");
      @(posedge sys_clk_i);
      dma_active_i <= 1'b1;
      diag_passed_i <= 1'b1;
      drive_active_i <= 1'b1;
      hw(11'h7F9, 2'h3, 16'hCAFE);
      take(11'h001, {2'h3, 16'hCAFE});
      chk(pin46_oe_n_o === 1'b0 && pin45_oe_n_o === 1'b0, "open drain pins");
      dma_active_i <= 1'b0;
      hw(11'h7F9, 2'h2, 16'hBEEF);
      take(11'h001, {2'h1, 16'h00EF});
      hw(11'h400, 2'h2, 16'h1234);
      take(11'h000, {2'h3, 16'h1234});
      dma_acknowledge_n_i <= 1'b1;
      u_host.setup(11'h7FE, 2'h1, 16'h0000);
      u_host.rd(1'b1);
      chk(core_rd_req_o === 1'b1 && core_rd_ctrl_o === 1'b1 && core_rd_addr_o === 11'h006, "control read");
      u_host.rd(1'b0);
      u_host.setup(11'h002, 2'h1, 16'h0000);
      u_host.rd(1'b1);
      chk(core_rd_req_o === 1'b0 && data_lo_oe_n_o === 1'b1, "refused index");
      u_host.rd(1'b0);
      u_host.setup(11'h0F3, 2'h2, 16'h0000);
      u_host.rd(1'b1);
      chk(core_rd_req_o === 1'b1 && core_rd_ctrl_o === 1'b0 && core_rd_addr_o === 11'h003 && data_lo_oe_n_o === 1'b0
         && data_hi_oe_n_o === 1'b1 && data_o[7:0] === r[7:0], "task file read");
      u_host.rd(1'b0);
      u_host.idle;
      // Ultra bursts remap pins 34, 35 and 42.
      udma_write_active_i <= 1'b1;
      device_burst_ready_n_i <= 1'b0;
      u_host.pins(1'b0, 1'b1);
      chk(host_data_strobe_o === 1'b1 && pin42_o === 1'b0 && stop_request_o === 1'b0, "write burst");
      u_host.pins(1'b1, 1'b0);
      chk(host_data_strobe_o === 1'b0 && stop_request_o === 1'b1, "burst stop");
      udma_write_active_i <= 1'b0;
      udma_read_active_i <= 1'b1;
      device_data_strobe_i <= 1'b1;
      u_host.pins(1'b0, 1'b1);
      chk(host_burst_ready_n_o === 1'b0 && pin42_o === 1'b1 && stop_request_o === 1'b0, "read burst");
      u_host.pins(1'b1, 1'b1);
      chk(host_burst_ready_n_o === 1'b1, "host pause");
      print_verdict;
   end
endmodule

// [logic/flash_card_pin_if.v]
// Host-side pin interface of a removable flash card with three access modes.
//
// What this block does
// - Disk mode decodes only low three address lines.
// - First select hits task file, second control pair.
// - In card modes high enable moves the odd byte.
// - Low enable moves even or odd byte.
// - Eight-bit host reaches every byte on low lines.
// - Line 0 even byte LSB, line 8 odd.
// - Drive role grounded primary, open secondary.
// - Card modes ignore drive role input.
// - Memory mode drives both battery outputs high.
// - I/O mode signals ready or protect changes.
// - I/O mode audio output, negated when absent.
// - DMA acknowledge ignored while no DMA active.
// - Ultra write burst remaps pins 34, 35, 42.
// - Ultra read burst remaps pins 34, 35, 42.
// - Upper lines and high enable may float.
// - Disk register bytes low lines, sector data 16-bit.
`timescale 1ns/10ps
`include "flash_card_pin_regs.vh"
module flash_card_pin_if
(
   input wire sys_clk_i,
   input wire rst_b_i,
   // Host pins, asynchronous to the clock.
   input wire [10:0] addr_i,
   input wire card_enable_low_n_i,
   input wire card_enable_high_n_i,
   input wire disk_mode_select_n_i,
   input wire write_enable_n_i,
   input wire io_read_strobe_n_i,
   input wire io_write_strobe_n_i,
   input wire drive_role_select_n_i,
   input wire dma_acknowledge_n_i,
   input wire [15:0] data_i,
   output reg [15:0] data_o,
   output reg data_lo_oe_n_o,
   output reg data_hi_oe_n_o,
   output reg pin45_o,
   output reg pin45_oe_n_o,
   output reg pin46_o,
   output reg pin46_oe_n_o,
   output reg pin42_o,
   // Card core side, same clock.
   input wire io_mode_cfg_i,
   input wire [15:0] core_rd_data_i,
   input wire core_ready_i,
   input wire ready_state_i,
   input wire write_protect_i,
   input wire status_change_enable_i,
   input wire status_change_clear_i,
   input wire audio_supported_i,
   input wire audio_i,
   input wire diag_passed_i,
   input wire drive_active_i,
   input wire dma_active_i,
   input wire udma_write_active_i,
   input wire udma_read_active_i,
   input wire device_burst_ready_n_i,
   input wire device_data_strobe_i,
   input wire core_wr_ready_i,
   output wire core_wr_valid_o,
   output wire [30:0] core_wr_entry_o,
   output reg core_rd_req_o,
   output reg [10:0] core_rd_addr_o,
   output reg core_rd_ctrl_o,
   output reg disk_compatible_mode_o,
   output reg io_card_mode_o,
   output reg drive_secondary_o,
   output reg host_data_strobe_o,
   output reg host_burst_ready_n_o,
   output reg stop_request_o
);

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   // Host pins pass two flops first.
   wire [34:0] pins_q;
   pin_sync #(
      .W(`FCP_SYNC_W),
      .RST_VAL(`FCP_SYNC_RST)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .d_i({data_i, dma_acknowledge_n_i, drive_role_select_n_i, io_write_strobe_n_i,
            io_read_strobe_n_i, write_enable_n_i, disk_mode_select_n_i,
            card_enable_high_n_i, card_enable_low_n_i, addr_i}),
      .q_o(pins_q)
   );

   // Synchronised pin levels.
   wire [10:0] a_s = pins_q[10:0];
   wire ce_lo_n_s = pins_q[11];
   wire ce_hi_n_s = pins_q[12];
   wire oe_n_s = pins_q[13];
   wire we_n_s = pins_q[14];
   wire io_read_strobe_n_n_s = pins_q[15];
   wire io_write_strobe_n_n_s = pins_q[16];
   wire role_n_s = pins_q[17];
   wire dma_acknowledge_n_n_s = pins_q[18];
   wire [15:0] d_s = pins_q[34:19];

   // -----------------------------------------------------------------
   // Mode capture
   // -----------------------------------------------------------------
   localparam [1:0] ST_BOOT = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;
   reg [1:0] state_r;
   reg [1:0] boot_cnt_r;

   // Samples the mode pin once the synchronisers are full.
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_r <= ST_BOOT;
         boot_cnt_r <= 2'h0;
         disk_compatible_mode_o <= 1'b0;
      end
      else
      begin
         case (state_r)
            ST_BOOT:
            begin
               boot_cnt_r <= boot_cnt_r + 2'h1;
               if (boot_cnt_r == `FCP_BOOT_CYCLES)
               begin
                  // Grounded pin selects disk mode.
                  disk_compatible_mode_o <= ~oe_n_s;
                  state_r <= ST_RUN;
               end
            end
            ST_RUN:
            begin
               state_r <= ST_RUN;
            end
            default:
            begin
               state_r <= ST_BOOT;
            end
         endcase
      end
   end

   // Card mode personality follows the core's configuration, disk mode wins.
   wire run = state_r[1];
   wire disk = disk_compatible_mode_o;
   wire io_mode = run & ~disk & io_mode_cfg_i;
   wire mem_mode = run & ~disk & ~io_mode_cfg_i;

   // -----------------------------------------------------------------
   // Access decode
   // -----------------------------------------------------------------
   // DMA acknowledge counts only during DMA.
   wire dma_sel = disk & dma_active_i & ~dma_acknowledge_n_n_s;
   // Task file uses only the low three address lines.
   wire [2:0] tf_idx = a_s[2:0];
   wire tf_sel = disk & ~dma_sel & ~ce_lo_n_s;
   // Second select reaches only the control pair.
   wire ctl_sel = disk & ~dma_sel & ~ce_hi_n_s & ce_lo_n_s & (tf_idx == `FCP_DATA_REG_IDX);
   // Sector data and DMA move 16 bits.
   wire disk_word = dma_sel | (tf_sel & (tf_idx == `FCP_SECTOR_IDX));
   wire card_sel = run & ~disk & (~ce_lo_n_s | ~ce_hi_n_s);
   wire any_sel = tf_sel | ctl_sel | dma_sel | card_sel;

   // Strobes per mode; write enable unused in disk mode.
   wire rd_n = mem_mode ? oe_n_s : io_read_strobe_n_n_s;
   wire wr_n = mem_mode ? we_n_s : io_write_strobe_n_n_s;
   wire udma = disk & (udma_write_active_i | udma_read_active_i);
   wire rd_act = run & any_sel & ~rd_n & ~udma;
   reg wr_n_d_r;
   // Writes land on the trailing edge of the strobe.
   wire wr_done = run & any_sel & wr_n & ~wr_n_d_r & ~udma;

   // Byte lane plan.
   reg word_c;
   reg odd_lo_c;
   // Decides lane use for card and disk accesses.
   always @*
   begin
      word_c = 1'b0;
      odd_lo_c = 1'b0;
      if (disk)
      begin
         word_c = disk_word;
      end
      else if (!ce_lo_n_s && !ce_hi_n_s)
      begin
         word_c = 1'b1;
      end
      else if (!ce_lo_n_s)
      begin
         // Low enable alone: A0 picks the byte.
         odd_lo_c = a_s[0];
      end
      else
      begin
         odd_lo_c = 1'b0;
      end
   end
   // High enable alone: odd byte, upper lines.
   wire hi_only = ~disk & ce_lo_n_s & ~ce_hi_n_s;

   // -----------------------------------------------------------------
   // Write path into the buffer
   // -----------------------------------------------------------------
   reg [15:0] wdata_c;
   reg [1:0] wbe_c;
   // Places host bytes into word lanes.
   always @*
   begin
      wdata_c = `FCP_DATA_RST;
      wbe_c = 2'b00;
      if (word_c)
      begin
         wdata_c = d_s;
         wbe_c = 2'b11;
      end
      else if (hi_only)
      begin
         wdata_c = {d_s[15:8], 8'h00};
         wbe_c = 2'b10;
      end
      else if (odd_lo_c)
      begin
         wdata_c = {d_s[7:0], 8'h00};
         wbe_c = 2'b10;
      end
      else
      begin
         wdata_c = {8'h00, d_s[7:0]};
         wbe_c = 2'b01;
      end
   end

   wire buf_in_ready;
   skid_buffer #(
      .W(`FCP_ENT_W)
   ) u_wbuf (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(wr_done),
      .in_data_i({ctl_sel, dma_sel, (disk ? {8'h00, tf_idx} : a_s), wbe_c, wdata_c}),
      .in_ready_o(buf_in_ready),
      .out_valid_o(core_wr_valid_o),
      .out_data_o(core_wr_entry_o),
      .out_ready_i(core_wr_ready_i)
   );

   // -----------------------------------------------------------------
   // Read path and data pins
   // -----------------------------------------------------------------
   // Steers core read data to the host lanes.
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wr_n_d_r <= 1'b1;
         data_o <= `FCP_DATA_RST;
         data_lo_oe_n_o <= 1'b1;
         data_hi_oe_n_o <= 1'b1;
         core_rd_req_o <= 1'b0;
         core_rd_addr_o <= 11'h000;
         core_rd_ctrl_o <= 1'b0;
      end
      else
      begin
         wr_n_d_r <= wr_n;
         core_rd_req_o <= rd_act;
         core_rd_addr_o <= disk ? {8'h00, tf_idx} : a_s;
         core_rd_ctrl_o <= ctl_sel;
         if (word_c)
         begin
            data_o <= core_rd_data_i;
         end
         else if (hi_only)
         begin
            data_o <= {core_rd_data_i[15:8], 8'h00};
         end
         else if (odd_lo_c)
         begin
            data_o <= {8'h00, core_rd_data_i[15:8]};
         end
         else
         begin
            data_o <= {8'h00, core_rd_data_i[7:0]};
         end
         data_lo_oe_n_o <= ~(rd_act & ~hi_only);
         data_hi_oe_n_o <= ~(rd_act & (word_c | hi_only));
      end
   end

   // -----------------------------------------------------------------
   // Status, audio, drive role and burst pins
   // -----------------------------------------------------------------
   reg rdy_d_r;
   reg wp_d_r;
   reg chg_pend_r;
   wire chg_evt = (ready_state_i ^ rdy_d_r) | (write_protect_i ^ wp_d_r);

   // Drives mode dependent side pins from flops.
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rdy_d_r <= 1'b0;
         wp_d_r <= 1'b0;
         chg_pend_r <= 1'b0;
         pin45_o <= 1'b1;
         pin45_oe_n_o <= 1'b1;
         pin46_o <= 1'b1;
         pin46_oe_n_o <= 1'b1;
         pin42_o <= 1'b0;
         io_card_mode_o <= 1'b0;
         drive_secondary_o <= 1'b0;
         host_data_strobe_o <= 1'b0;
         host_burst_ready_n_o <= 1'b1;
         stop_request_o <= 1'b0;
      end
      else
      begin
         rdy_d_r <= ready_state_i;
         wp_d_r <= write_protect_i;
         io_card_mode_o <= io_mode;
         // A change in the same cycle as the clear is kept.
         if (chg_evt)
         begin
            chg_pend_r <= 1'b1;
         end
         else if (status_change_clear_i)
         begin
            chg_pend_r <= 1'b0;
         end
         // Open pin reads high: secondary drive.
         drive_secondary_o <= disk & role_n_s;
         if (mem_mode)
         begin
            pin45_o <= 1'b1;
            pin46_o <= 1'b1;
            pin45_oe_n_o <= 1'b0;
            pin46_oe_n_o <= 1'b0;
         end
         else if (io_mode)
         begin
            pin46_o <= ~(status_change_enable_i & chg_pend_r);
            pin45_o <= ~(audio_supported_i & audio_i);
            pin46_oe_n_o <= 1'b0;
            pin45_oe_n_o <= 1'b0;
         end
         else
         begin
            // Disk mode: open drain lines; high while booting.
            pin46_o <= ~disk;
            pin45_o <= ~disk;
            pin46_oe_n_o <= ~(disk & diag_passed_i);
            pin45_oe_n_o <= ~(disk & drive_active_i);
         end
         // Burst pin roles; otherwise ready, low when full.
         host_data_strobe_o <= disk & udma_write_active_i & ~io_read_strobe_n_n_s;
         host_burst_ready_n_o <= ~(disk & udma_read_active_i & ~io_read_strobe_n_n_s);
         stop_request_o <= udma & ~io_write_strobe_n_n_s;
         if (disk && udma_write_active_i)
         begin
            pin42_o <= device_burst_ready_n_i;
         end
         else if (disk && udma_read_active_i)
         begin
            pin42_o <= device_data_strobe_i;
         end
         else
         begin
            pin42_o <= core_ready_i & buf_in_ready;
         end
      end
   end

endmodule

// [logic/flash_card_pin_regs.vh]
// Constants for the flash card host pin interface.
`ifndef FLASH_CARD_PIN_REGS_VH
`define FLASH_CARD_PIN_REGS_VH

// Widths of the pin groups.
`define FCP_ADDR_W 11
`define FCP_DATA_W 16
`define FCP_SYNC_W 35

// Positions of the fields in one buffered write entry.
`define FCP_ENT_DATA_LSB 0
`define FCP_ENT_BE_LSB 16
`define FCP_ENT_ADDR_LSB 18
`define FCP_ENT_DMA_BIT 29
`define FCP_ENT_CTRL_BIT 30
`define FCP_ENT_W 31

// Task-file index of the control register pair, and of the sector data register.
`define FCP_DATA_REG_IDX 3'h6
`define FCP_SECTOR_IDX 3'h0

// Reset values.
`define FCP_SYNC_RST 35'h7_FFFF_FFFF
`define FCP_DATA_RST 16'h0000

// Cycles allowed for the input synchronisers to fill before the mode is caught.
`define FCP_BOOT_CYCLES 2'h3

`endif

// [logic/pin_sync.v]
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/10ps
module pin_sync #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b1}}
)
(
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire [W-1:0] d_i,
   output reg [W-1:0] q_o
);

   // First stage, read only by the second stage.
   reg [W-1:0] meta_r;

   // -----------------------------------------------------------------
   // Two stage capture
   // -----------------------------------------------------------------
   // Both stages take the idle level under reset.
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta_r <= RST_VAL;
         q_o <= RST_VAL;
      end
      else
      begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end

endmodule

// [logic/skid_buffer.v]
// Two-entry buffer with valid and ready on both sides, outputs from flops.
`timescale 1ns/10ps
module skid_buffer #(
   parameter W = 8
)
(
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire in_valid_i,
   input wire [W-1:0] in_data_i,
   output reg in_ready_o,
   output reg out_valid_o,
   output reg [W-1:0] out_data_o,
   input wire out_ready_i
);

   // Second entry, filled only when the output entry is stalled.
   reg skid_valid_r;
   reg [W-1:0] skid_data_r;

   // Handshakes on each side this cycle.
   wire push = in_valid_i & in_ready_o;
   wire pop = out_valid_o & out_ready_i;

   // -----------------------------------------------------------------
   // Entry control
   // -----------------------------------------------------------------
   // Output refills from the skid entry first.
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         out_valid_o <= 1'b0;
         out_data_o <= {W{1'b0}};
         skid_valid_r <= 1'b0;
         skid_data_r <= {W{1'b0}};
         in_ready_o <= 1'b1;
      end
      else
      begin
         if (!out_valid_o || pop)
         begin
            // Output entry is free: take the oldest word available.
            if (skid_valid_r)
            begin
               out_valid_o <= 1'b1;
               out_data_o <= skid_data_r;
               skid_valid_r <= push;
               skid_data_r <= in_data_i;
            end
            else
            begin
               out_valid_o <= push;
               out_data_o <= in_data_i;
            end
         end
         else if (push)
         begin
            // Output stalled: park the new word.
            skid_valid_r <= 1'b1;
            skid_data_r <= in_data_i;
         end
         // Ready drops once both entries hold words.
         in_ready_o <= ~((out_valid_o & ~pop) & (skid_valid_r | push)) &
                       ~(skid_valid_r & push & ~pop);
      end
   end

endmodule
